//--- design/sram_pkg.sv
// Contract
// - address on k rise, data both rises
// - controller drives k_n as inverse of k
// - output timing from c pair, else k pair
// - echo clocks free running, aligned with data
// - loop disabled: bypass, drop lock state
// - loop enabled: lock after lock interval
// - bypass gives single cycle read latency
// - address ignored without read or write
// - 18-bit or 36-bit data organisation
// - low write strobe starts write burst
// - low read strobe starts read burst
// - byte strobes sampled with their beat
// - read bus driven only for reads
// - reads at most every other cycle
// - write beats start one cycle later
// - first read beat 1.5 cycles later with loop enabled
// - reads see two newest write buffers
package sram_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int BURST = 4;
  localparam int ADDR_W = 18;
  localparam real CLK_NS = 10.0;
  localparam int LOCK_CYCLES = 2048;
  localparam real KSTOP_NS = 30.0;
  localparam int KSTOP_CYC = int'($ceil(KSTOP_NS / CLK_NS));
  localparam real BYPASS_MAX_MHZ = 167.0;
  // latency in half link cycles (one system cycle each)
  localparam int LAT_LOOP_HALF = 3;
  localparam int LAT_BYPASS_HALF = 2;
  localparam int WBEAT_SLOT = 2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_BEAT1 = 2'b01,
    WR_BEAT2 = 2'b10,
    WR_BEAT3 = 2'b11
  } wr_stage_e;
endpackage

//--- design/sram_if.sv
`timescale 1ns/10ps
interface sram_if #(
  parameter int DW = 36,
  parameter int AW = 18
);
  localparam int NL = DW / 9;
  logic k;
  logic k_n;
  logic c;
  logic c_n;
  logic loop_run;
  logic read_n;
  logic write_n;
  logic [AW-1:0] mem_addr;
  logic [DW-1:0] write_data_in;
  logic [NL-1:0] byte_write_n;
  logic [DW-1:0] read_data_out;
  logic read_data_oe;
  logic echo_clk_true;
  logic echo_clk_comp;

  modport dev (
    input k, k_n, c, c_n, loop_run, read_n, write_n, mem_addr,
    input write_data_in, byte_write_n,
    output read_data_out, read_data_oe, echo_clk_true, echo_clk_comp
  );
  modport ctl (
    output k, k_n, c, c_n, loop_run, read_n, write_n, mem_addr,
    output write_data_in, byte_write_n,
    input read_data_out, read_data_oe, echo_clk_true, echo_clk_comp
  );
endinterface

//--- design/sram_dev.sv
`timescale 1ns/10ps
module sram_dev #(
  parameter int DW = sram_pkg::DATA_W,
  parameter int AW = sram_pkg::ADDR_W,
  parameter int LOCK = sram_pkg::LOCK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // link
  sram_if.dev link,
  // status
  output logic dll_locked_out
);
  localparam int LW = sram_pkg::LANE_W;
  // organisation follows DW (18 or 36)
  localparam int NL = DW / LW;
  localparam int LCW = $clog2(LOCK + 1);

  typedef logic [3:0][DW-1:0] burst_t;
  typedef logic [3:0][NL-1:0] mask_t;

  typedef struct packed {
    logic valid;
    logic [AW-1:0] addr;
    burst_t data;
    mask_t mask;
  } wbuf_s;

  typedef struct packed {
    logic k_prev;
    logic kn_prev;
    logic [3:0] idle_cnt;
    logic [LCW-1:0] lock_cnt;
    logic locked;
    logic pend_valid;
    logic [AW-1:0] pend_addr;
    sram_pkg::wr_stage_e wr_stage;
    logic [AW-1:0] cur_addr;
    burst_t cur_data;
    mask_t cur_mask;
    wbuf_s wb_new;
    wbuf_s wb_old;
    logic [1:0] rd_wait;
    burst_t rd_cap;
    logic rd_on;
    logic [1:0] rd_idx;
    burst_t rd_out;
    logic [DW-1:0] q;
    logic q_oe;
    logic echo_t;
    logic echo_c;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic push;
  logic k_rise;
  logic kn_rise;
  logic out_tied;
  logic sel_t;
  logic sel_c;
  logic out_edge;
  logic [DW-1:0] mem [0:(2**AW)*4-1];

  // only lanes with a low strobe take new data
  function automatic logic [DW-1:0] merge(
    input logic [DW-1:0] base,
    input logic [DW-1:0] upd,
    input logic [NL-1:0] bw_n
  );
    logic [DW-1:0] r;
    r = base;
    for (int l = 0; l < NL; l++) begin
      if (!bw_n[l]) begin
        r[l*LW +: LW] = upd[l*LW +: LW];
      end
    end
    return r;
  endfunction

  function automatic logic [AW+1:0] widx(
    input logic [AW-1:0] a,
    input int b
  );
    return {a, 2'(b)};
  endfunction

  // commands on k rise only, data on k and k_n rises
  assign k_rise = link.k & ~st_reg.k_prev;
  assign kn_rise = link.k_n & ~st_reg.kn_prev;
  // both output clocks high hands timing to the k pair
  assign out_tied = link.c & link.c_n;
  assign sel_t = out_tied ? link.k : link.c;
  assign sel_c = out_tied ? link.k_n : link.c_n;
  assign out_edge = (sel_t & ~st_reg.echo_t) | (sel_c & ~st_reg.echo_c);

  always_comb begin
    logic [DW-1:0] v;
    v = '0;
    st_next = st_reg;
    push = 1'b0;
    st_next.k_prev = link.k;
    st_next.kn_prev = link.k_n;
    // echo clocks follow the selected pair, even when idle
    st_next.echo_t = sel_t;
    st_next.echo_c = sel_c;

    if (k_rise || kn_rise) begin
      st_next.idle_cnt = '0;
    end else if (st_reg.idle_cnt != 4'(sram_pkg::KSTOP_CYC)) begin
      st_next.idle_cnt = st_reg.idle_cnt + 4'h1;
    end
    // loop off or stopped clock clears lock state
    if (!link.loop_run ||
        st_reg.idle_cnt == 4'(sram_pkg::KSTOP_CYC)) begin
      st_next.lock_cnt = '0;
      st_next.locked = 1'b0;
    // lock after LOCK rising edges of stable k
    end else if (k_rise && st_reg.lock_cnt != LCW'(LOCK)) begin
      st_next.lock_cnt = st_reg.lock_cnt + LCW'(1);
      st_next.locked = (st_reg.lock_cnt + LCW'(1)) == LCW'(LOCK);
    end

    // beats 0 and 2 on k rises after the command
    if (k_rise) begin
      case (st_reg.wr_stage)
        sram_pkg::WR_IDLE: begin
          if (st_reg.pend_valid) begin
            st_next.cur_addr = st_reg.pend_addr;
            st_next.cur_data[0] = link.write_data_in;
            st_next.cur_mask[0] = link.byte_write_n;
            st_next.wr_stage = sram_pkg::WR_BEAT1;
          end
        end
        sram_pkg::WR_BEAT2: begin
          st_next.cur_data[2] = link.write_data_in;
          st_next.cur_mask[2] = link.byte_write_n;
          st_next.wr_stage = sram_pkg::WR_BEAT3;
        end
        default: begin
        end
      endcase
      // low write strobe registers address, starts burst
      st_next.pend_valid = ~link.write_n;
      // address is taken only with a strobe low
      if (!link.write_n) begin
        st_next.pend_addr = link.mem_addr;
      end
    end

    // beats 1 and 3 on k_n rises
    if (kn_rise) begin
      case (st_reg.wr_stage)
        sram_pkg::WR_BEAT1: begin
          st_next.cur_data[1] = link.write_data_in;
          st_next.cur_mask[1] = link.byte_write_n;
          st_next.wr_stage = sram_pkg::WR_BEAT2;
        end
        sram_pkg::WR_BEAT3: begin
          st_next.wb_old = st_reg.wb_new;
          st_next.wb_new.valid = 1'b1;
          st_next.wb_new.addr = st_reg.cur_addr;
          st_next.wb_new.data = st_reg.cur_data;
          st_next.wb_new.data[3] = link.write_data_in;
          st_next.wb_new.mask = st_reg.cur_mask;
          st_next.wb_new.mask[3] = link.byte_write_n;
          st_next.wr_stage = sram_pkg::WR_IDLE;
          push = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // output registers step on edges of the selected clock pair
    if (out_edge) begin
      st_next.q = '0;
      st_next.q_oe = 1'b0;
      if (st_reg.rd_on && st_reg.rd_idx != 2'h3) begin
        st_next.rd_idx = st_reg.rd_idx + 2'h1;
        st_next.q = st_reg.rd_out[st_next.rd_idx];
        st_next.q_oe = 1'b1;
      end else begin
        st_next.rd_on = 1'b0;
      end
      if (st_reg.rd_wait == 2'h1) begin
        st_next.rd_on = 1'b1;
        st_next.rd_idx = 2'h0;
        st_next.rd_out = st_reg.rd_cap;
        st_next.q = st_reg.rd_cap[0];
        st_next.q_oe = 1'b1;
      end
      if (st_reg.rd_wait != 2'h0) begin
        st_next.rd_wait = st_reg.rd_wait - 2'h1;
      end
    end

    // low read strobe captures the burst at the address, starts read
    if (k_rise && !link.read_n) begin
      for (int b = 0; b < 4; b++) begin
        v = mem[widx(link.mem_addr, b)];
        // older buffer first, newer one overrides
        if (st_reg.wb_old.valid && st_reg.wb_old.addr == link.mem_addr) begin
          v = merge(v, st_reg.wb_old.data[b], st_reg.wb_old.mask[b]);
        end
        if (st_reg.wb_new.valid && st_reg.wb_new.addr == link.mem_addr) begin
          v = merge(v, st_reg.wb_new.data[b], st_reg.wb_new.mask[b]);
        end
        st_next.rd_cap[b] = v;
      end
      // 1.5 cycles with loop running; 1 cycle bypassed
      st_next.rd_wait = link.loop_run ?
        2'(sram_pkg::LAT_LOOP_HALF - 1) :
        2'(sram_pkg::LAT_BYPASS_HALF - 1);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      // k_n idles high in reset, so no false rise after release
      st_reg.kn_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // buffer leaving by the third write is committed to the array
  always_ff @(posedge clk_sys_in) begin
    if (push && st_reg.wb_old.valid) begin
      for (int b = 0; b < 4; b++) begin
        mem[widx(st_reg.wb_old.addr, b)] <= merge(
          mem[widx(st_reg.wb_old.addr, b)],
          st_reg.wb_old.data[b], st_reg.wb_old.mask[b]);
      end
    end
  end

  // data bus carries zero unless a read beat is out
  assign link.read_data_out = st_reg.q;
  assign link.read_data_oe = st_reg.q_oe;
  assign link.echo_clk_true = st_reg.echo_t;
  assign link.echo_clk_comp = st_reg.echo_c;
  assign dll_locked_out = st_reg.locked;
endmodule

//--- design/sram_ctl.sv
`timescale 1ns/10ps
module sram_ctl #(
  parameter int DW = sram_pkg::DATA_W,
  parameter int AW = sram_pkg::ADDR_W
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // link
  sram_if.ctl link,
  // requests
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [AW-1:0] req_addr_in,
  input wire logic [4*DW-1:0] req_wdata_in,
  input wire logic [4*(DW/9)-1:0] req_bw_n_in,
  output logic req_ready_out,
  // mode
  input wire logic loop_run_in,
  input wire logic single_clock_in,
  // read answers
  output logic [4*DW-1:0] rd_data_out,
  output logic rd_valid_out
);
  localparam int NL = DW / sram_pkg::LANE_W;

  typedef struct packed {
    logic [DW-1:0] d;
    logic [NL-1:0] bw_n;
  } beat_s;

  typedef struct packed {
    logic phase;
    logic kn;
    logic c;
    logic cn;
    logic loop_run;
    logic ready;
    logic busy;
    logic read_n;
    logic write_n;
    logic [AW-1:0] addr;
    beat_s [5:0] sr;
    logic [1:0] cap_idx;
    logic [3:0][DW-1:0] cap;
    logic [4*DW-1:0] rd_data;
    logic rd_valid;
  } state_s;

  state_s st_reg;
  state_s st_next;
  beat_s idle_beat;

  assign idle_beat = '{d: '0, bw_n: '1};

  always_comb begin
    st_next = st_reg;
    // k_n always the inverse of k, never parked
    st_next.phase = ~st_reg.phase;
    st_next.kn = st_reg.phase;
    st_next.c = single_clock_in | ~st_reg.phase;
    st_next.cn = single_clock_in | st_reg.phase;
    st_next.loop_run = loop_run_in;
    st_next.rd_valid = 1'b0;
    st_next.sr = {idle_beat, st_reg.sr[5:1]};
    if (!st_reg.phase) begin
      st_next.read_n = 1'b1;
      st_next.write_n = 1'b1;
      st_next.busy = 1'b0;
      if (st_reg.ready && req_valid_in) begin
        st_next.busy = 1'b1;
        st_next.addr = req_addr_in;
        st_next.read_n = req_write_in;
        st_next.write_n = ~req_write_in;
        // beat 0 meets the next k rise
        if (req_write_in) begin
          for (int b = 0; b < 4; b++) begin
            st_next.sr[sram_pkg::WBEAT_SLOT + b] = '{
              d: req_wdata_in[b*DW +: DW],
              bw_n: req_bw_n_in[b*NL +: NL]};
          end
        end
      end
    end
    // one command per two link cycles
    st_next.ready = st_reg.phase && !st_reg.busy;
    if (link.read_data_oe) begin
      st_next.cap[st_reg.cap_idx] = link.read_data_out;
      st_next.cap_idx = st_reg.cap_idx + 2'h1;
      if (st_reg.cap_idx == 2'h3) begin
        st_next.rd_data = {link.read_data_out, st_reg.cap[2:0]};
        st_next.rd_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.kn <= 1'b1;
      st_reg.cn <= 1'b1;
      st_reg.read_n <= 1'b1;
      st_reg.write_n <= 1'b1;
      st_reg.sr <= '{default: '{d: '0, bw_n: '1}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.k = st_reg.phase;
  assign link.k_n = st_reg.kn;
  assign link.c = st_reg.c;
  assign link.c_n = st_reg.cn;
  assign link.loop_run = st_reg.loop_run;
  assign link.read_n = st_reg.read_n;
  assign link.write_n = st_reg.write_n;
  assign link.mem_addr = st_reg.addr;
  // strobes travel with their data beat
  assign link.write_data_in = st_reg.sr[0].d;
  assign link.byte_write_n = st_reg.sr[0].bw_n;
  assign req_ready_out = st_reg.ready;
  assign rd_data_out = st_reg.rd_data;
  assign rd_valid_out = st_reg.rd_valid;
endmodule

//--- dv/sram_link_monitor.sv
`timescale 1ns/10ps
module sram_link_monitor #(
  parameter int DW = 36,
  parameter int AW = 18
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // link
  input wire logic k,
  input wire logic k_n,
  input wire logic loop_run,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [DW-1:0] read_data_out,
  input wire logic read_data_oe,
  input wire logic echo_clk_true,
  input wire logic echo_clk_comp
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  chk_comp_clock: assert property (k_n != k)
    else $error("k_n is not the inverse of k");
  chk_link_toggle: assert property (k |=> !k)
    else $error("k stopped toggling");
  chk_loop_latency: assert property (
    k && !read_n && loop_run |-> ##3 read_data_oe [*4])
    else $error("read burst late with loop running");
  chk_bypass_latency: assert property (
    k && !read_n && !loop_run |-> ##2 read_data_oe [*4])
    else $error("read burst late with loop bypassed");
  chk_oe_cause: assert property (
    $rose(read_data_oe) |-> !$past(read_n, 2))
    else $error("read bus driven without read");
  chk_idle_data: assert property (
    !read_data_oe |-> read_data_out == '0)
    else $error("read data while not driving");
  chk_echo_run: assert property (
    echo_clk_true |=> !echo_clk_true && echo_clk_comp)
    else $error("echo clocks not running");
  chk_cmd_hold: assert property (
    k && !read_n |=> !read_n && $stable(mem_addr))
    else $error("read command not held");
  chk_read_spacing: assert property (
    k && !read_n |=> !read_n ##1 (read_n && write_n)
      ##1 (read_n && write_n))
    else $error("read command closer than two link cycles");
  chk_echo_follow: assert property (
    k |=> echo_clk_true && !echo_clk_comp)
    else $error("echo clocks not following the clock pair");
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam int AW = 6;
  logic clk_sys_in, rst_in, req_valid, req_write, req_ready;
  logic loop_run, single_clk, rd_valid, dll_locked;
  logic [AW-1:0] req_addr;
  logic [143:0] req_wdata, rd_data;
  logic [15:0] req_bw_n;
  logic [35:0] mem [0:31];
  logic [143:0] exp_q[$];
  logic [31:0] seed;
  int fails, checked, n;

  sram_if #(.DW(36), .AW(AW)) sram_if_i ();
  sram_dev #(.AW(AW), .LOCK(16)) sram_dev_i (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .link(sram_if_i), .dll_locked_out(dll_locked));
  sram_ctl #(.AW(AW)) sram_ctl_i (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .link(sram_if_i), .req_valid_in(req_valid),
    .req_write_in(req_write), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .req_bw_n_in(req_bw_n),
    .req_ready_out(req_ready), .loop_run_in(loop_run),
    .single_clock_in(single_clk), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid));
  sram_link_monitor #(.DW(36), .AW(AW)) sram_link_monitor_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .k(sram_if_i.k),
    .k_n(sram_if_i.k_n), .loop_run(sram_if_i.loop_run),
    .read_n(sram_if_i.read_n), .write_n(sram_if_i.write_n),
    .mem_addr(sram_if_i.mem_addr),
    .read_data_out(sram_if_i.read_data_out),
    .read_data_oe(sram_if_i.read_data_oe),
    .echo_clk_true(sram_if_i.echo_clk_true),
    .echo_clk_comp(sram_if_i.echo_clk_comp));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string what, logic [143:0] e, logic [143:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wait_clk(int c);
    repeat (c) @(posedge clk_sys_in);
  endtask

  task automatic idle(int c);
    req_valid <= 1'h0;
    wait_clk(c);
  endtask

  // full writes keep the shadow defined; partial ones use random lanes
  task automatic issue(logic w, int a, logic full);
    logic [159:0] r;
    logic [143:0] e;
    int t;
    r = {rnd(), rnd(), rnd(), rnd(), rnd()};
    if (full)
      r[159:144] = 16'h0000;
    t = 0;
    req_valid <= 1'h1;
    req_write <= w;
    req_addr <= AW'(a);
    req_wdata <= r[143:0];
    req_bw_n <= r[159:144];
    @(posedge clk_sys_in);
    while (req_ready !== 1'h1) begin
      t++;
      if (t > 40) begin
        fails++;
        report_and_stop();
      end
      @(posedge clk_sys_in);
    end
    for (int b = 0; b < 4; b++) begin
      e[b*36+:36] = mem[a*4+b];
      for (int l = 0; l < 4; l++)
        if (w && !r[144+b*4+l])
          mem[a*4+b][l*9+:9] = r[b*36+l*9+:9];
    end
    if (!w)
      exp_q.push_back(e);
  endtask

  always @(posedge clk_sys_in) begin
    if (rd_valid === 1'h1) begin
      if (exp_q.size() == 0)
        check("unexpected read", 144'h0, 144'h1);
      else
        check("read data", exp_q.pop_front(), rd_data);
    end
  end

  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    seed = 32'h00001ac0;
    rst_in = 1'h1;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = '0;
    req_wdata = '0;
    req_bw_n = 16'hffff;
    loop_run = 1'h0;
    single_clk = 1'h0;
    wait_clk(3);
    rst_in <= 1'h0;
    wait_clk(4);
    loop_run <= 1'h1;
    wait_clk(20);
    check("lock too early", 144'h0, 144'(dll_locked));
    n = 0;
    while (dll_locked !== 1'h1 && n < 60) begin
      n++;
      @(posedge clk_sys_in);
    end
    check("lock", 144'h1, 144'(dll_locked));
    loop_run <= 1'h0;
    wait_clk(6);
    check("lock dropped", 144'h0, 144'(dll_locked));
    $display("test lock done");
    for (int m = 0; m < 4; m++) begin
      loop_run <= m[0];
      single_clk <= m[1];
      idle(40);
      for (int i = 0; i < 4; i++)
        issue(1'h1, i, 1'h1);
      for (int i = 0; i < 4; i++)
        issue(1'h1, i, 1'h0);
      idle(8);
      for (int i = 0; i < 4; i++)
        issue(1'h0, i, 1'h0);
      idle(1);
      n = 0;
      while (exp_q.size() > 0 && n < 50) begin
        n++;
        @(posedge clk_sys_in);
      end
      check("reads left", 144'h0, 144'(exp_q.size()));
      $display("test mode %0d done", m);
    end
    report_and_stop();
  end
endmodule
